/* File: asru_top.sv */
// Arithmetic shift-right unit with an AXI4-Lite register slave
// Operation
// - Word one-bit shift: source bit 15 fills bits 15,14; bits 14:1 move down.
// - Byte bit selects width; byte shift: bit 7 fills 7,6; bits 6:1 move down.
// - One-bit shift loads the source bit 0 into carry.
// - One-bit shift updates negative, zero, carry only.
// - One-bit shift accepts direct, indirect, post-inc, post-dec, pre-dec operands.
// - One-bit opcode: q destination mode, d destination, p source mode, s source.
// - One-bit shift is one word and one cycle.
// - Literal variant shifts by the four-bit unsigned literal, 0 to 15.
// - Multi-bit shifts replicate base bit 15 into vacated top bits.
// - Literal opcode: w base, d destination, k literal.
// - Literal variant uses direct registers only.
// - Multi-bit shifts update negative and zero only, carry kept.
// - Register-count variant shifts by count register bits 3:0.
// - Count opcode: w base, d destination, s count; direct registers only.
// - Count above 15 may saturate to all sign bits, selectable.
// - Multi-bit shifts are word only, one word, one cycle.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module asru_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} asru_state_t;

   // Refuse address widths that cannot hold the register map
   if (ADDR_W < 8) begin : g_addr_chk
      $error("asru_top: ADDR_W must be at least 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [23:0] instr_r;
   logic [15:0] opnd_r;
   logic [15:0] cnt_r;
   logic [15:0] stw_in_r;
   logic [31:0] ptr_in_r;
   logic sat_en_r;
   logic [15:0] result_r;
   logic [15:0] stw_out_r;
   logic [31:0] ptr_out_r;
   logic [31:0] ea_r;
   logic done_r, ill_r, byte_r, dmem_r, smem_r;
   logic [3:0] didx_r;
   asru_state_t state_r;
   logic aw_hold_r, w_hold_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   // Offset is valid only when aligned and inside the low window
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return ((a >> asru_pkg::OFFS_W) == '0) && (a[1:0] == 2'h0);
   endfunction

   // Readable value of a register, zero where unmapped
   function automatic logic [31:0] reg_val(input logic [7:0] o);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (o)
         asru_pkg::A_INSTR: v[23:0] = instr_r;
         asru_pkg::A_OPND: v[15:0] = opnd_r;
         asru_pkg::A_CNT: v[15:0] = cnt_r;
         asru_pkg::A_STW_IN: v[15:0] = stw_in_r;
         asru_pkg::A_PTR_IN: v = ptr_in_r;
         asru_pkg::A_CTRL: v[asru_pkg::CT_SAT] = sat_en_r;
         asru_pkg::A_RESULT: v[15:0] = result_r;
         asru_pkg::A_STW_OUT: v[15:0] = stw_out_r;
         asru_pkg::A_PTR_OUT: v = ptr_out_r;
         asru_pkg::A_EA: v = ea_r;
         asru_pkg::A_STAT: begin
            v[asru_pkg::ST_DONE] = done_r;
            v[asru_pkg::ST_ILL] = ill_r;
            v[asru_pkg::ST_BYTE] = byte_r;
            v[asru_pkg::ST_DMEM] = dmem_r;
            v[asru_pkg::ST_SMEM] = smem_r;
            v[asru_pkg::ST_DIDX +: 4] = didx_r;
         end
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Offset is a known register
   function automatic logic mapped(input logic [7:0] o);
      return o <= asru_pkg::A_STAT;
   endfunction

   // Sign-filling right shift of a word
   function automatic logic [15:0] asr16(input logic [15:0] x, input logic [3:0] n);
      return $unsigned($signed(x) >>> n);
   endfunction

   // Only the modes this shift supports are legal
   function automatic logic mode_ok(input logic [2:0] m);
      return m <= asru_pkg::M_PREDEC;
   endfunction

   // Effective address and updated pointer, as {ea, new pointer}
   function automatic logic [31:0] ptr_step(input logic [2:0] m, input logic [15:0] p,
                                           input logic [15:0] st);
      logic [15:0] dn;
      dn = p - st;
      case (m)
         asru_pkg::M_IND: return {p, p};
         asru_pkg::M_PDEC: return {p, dn};
         asru_pkg::M_PINC: return {p, 16'(p + st)};
         asru_pkg::M_PREDEC: return {dn, dn};
         default: return {16'h0000, p};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side
   logic wr_fire, start;
   logic [7:0] aw_off;
   logic [31:0] wmerge_c;
   assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   assign aw_off = aw_addr_r[7:0];
   assign start = wr_fire & addr_ok(aw_addr_r) & (aw_off == asru_pkg::A_INSTR);

   // Byte lanes merge into the current register value
   always_comb begin
      logic [31:0] cur;
      cur = reg_val(aw_off);
      for (int i = 0; i < 4; i++) begin
         wmerge_c[i*8 +: 8] = w_strb_r[i] ? w_data_r[i*8 +: 8] : cur[i*8 +: 8];
      end
   end

   // Address and data are taken in either order and held until the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_hold_r & ~s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~w_hold_r & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Response follows both halves; unknown offsets answer SLVERR
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= asru_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (addr_ok(aw_addr_r) && mapped(aw_off)) ?
                        asru_pkg::RESP_OKAY : asru_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software-written operand and control registers; results are read-only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_r <= 24'h00_0000;
         opnd_r <= 16'h0000;
         cnt_r <= 16'h0000;
         stw_in_r <= 16'h0000;
         ptr_in_r <= 32'h0000_0000;
         sat_en_r <= 1'b0;
      end else if (wr_fire && addr_ok(aw_addr_r)) begin
         case (aw_off)
            asru_pkg::A_INSTR: instr_r <= wmerge_c[asru_pkg::INSTR_W-1:0];
            asru_pkg::A_OPND: opnd_r <= wmerge_c[15:0];
            asru_pkg::A_CNT: cnt_r <= wmerge_c[15:0];
            asru_pkg::A_STW_IN: stw_in_r <= wmerge_c[15:0];
            asru_pkg::A_PTR_IN: ptr_in_r <= wmerge_c;
            asru_pkg::A_CTRL: sat_en_r <= wmerge_c[asru_pkg::CT_SAT];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= asru_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= addr_ok(s_axi_araddr) ? reg_val(s_axi_araddr[7:0]) : '0;
            s_axi_rresp <= (addr_ok(s_axi_araddr) && mapped(s_axi_araddr[7:0])) ?
                           asru_pkg::RESP_OKAY : asru_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode and shift datapath
   logic one_c, lit_c, reg_c, byte_c, sat_c, ill_c;
   logic [2:0] qm, pm;
   logic [15:0] step_c, res_c, stw_c;
   logic [31:0] sp_c, dp_c;
   assign qm = instr_r[asru_pkg::F_Q_HI:asru_pkg::F_Q_LO];
   assign pm = instr_r[asru_pkg::F_P_HI:asru_pkg::F_P_LO];

   // Opcode match picks the variant; count selector splits the multi-bit forms
   always_comb begin
      logic multi;
      logic [2:0] sel;
      multi = instr_r[asru_pkg::F_OP_HI:asru_pkg::F_OP_LO] == asru_pkg::OP_MULTI;
      sel = instr_r[asru_pkg::F_P_HI:asru_pkg::F_P_LO];
      one_c = instr_r[asru_pkg::F_OP_HI:asru_pkg::F_OP_LO] == asru_pkg::OP_ONE;
      lit_c = multi && (sel == asru_pkg::SEL_LIT);
      reg_c = multi && (sel == asru_pkg::SEL_REG);
      byte_c = one_c && instr_r[asru_pkg::F_B];
      ill_c = !(one_c || lit_c || reg_c) || (one_c && !(mode_ok(qm) && mode_ok(pm)));
      sat_c = reg_c && sat_en_r && (cnt_r > asru_pkg::MAX_SHIFT);
   end

   // Pointer stepping; multi-bit forms are register-direct so pointers stay
   always_comb begin
      step_c = byte_c ? asru_pkg::STEP_B : asru_pkg::STEP_W;
      sp_c = ptr_step(one_c ? pm : asru_pkg::M_DIR, ptr_in_r[15:0], step_c);
      dp_c = ptr_step(one_c ? qm : asru_pkg::M_DIR, ptr_in_r[31:16], step_c);
   end

   // Result and flags; the byte form leaves the upper byte zero for the core to merge
   always_comb begin
      res_c = 16'h0000;
      stw_c = stw_in_r;
      if (one_c && byte_c) begin
         res_c[7:0] = {opnd_r[7], opnd_r[7:1]};
      end else if (one_c) begin
         res_c = {opnd_r[15], opnd_r[15:1]};
      end else if (sat_c) begin
         res_c = {16{opnd_r[15]}};
      end else if (lit_c) begin
         res_c = asr16(opnd_r, instr_r[asru_pkg::F_S_HI:asru_pkg::F_S_LO]);
      end else if (reg_c) begin
         res_c = asr16(opnd_r, cnt_r[3:0]);
      end
      stw_c[asru_pkg::STW_N] = byte_c ? res_c[7] : res_c[15];
      stw_c[asru_pkg::STW_Z] = byte_c ? (res_c[7:0] == 8'h00) : (res_c == 16'h0000);
      if (one_c) begin
         stw_c[asru_pkg::STW_C] = opnd_r[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Execution sequencing: one cycle after the instruction write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: state_r <= start ? ST_EXEC : ST_IDLE;
            ST_EXEC: state_r <= start ? ST_EXEC : ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Done is set by completion and cleared by a new instruction; set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= 1'b0;
      end else if (state_r == ST_EXEC) begin
         done_r <= 1'b1;
      end else if (start) begin
         done_r <= 1'b0;
      end
   end

   // Results latch in the execute cycle; an illegal word keeps the result and copies the input status word out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= 16'h0000;
         stw_out_r <= 16'h0000;
         ptr_out_r <= 32'h0000_0000;
         ea_r <= 32'h0000_0000;
         ill_r <= 1'b0;
         byte_r <= 1'b0;
         dmem_r <= 1'b0;
         smem_r <= 1'b0;
         didx_r <= 4'h0;
      end else if (state_r == ST_EXEC) begin
         ill_r <= ill_c;
         byte_r <= byte_c;
         didx_r <= instr_r[asru_pkg::F_D_HI:asru_pkg::F_D_LO];
         dmem_r <= one_c && (qm != asru_pkg::M_DIR);
         smem_r <= one_c && (pm != asru_pkg::M_DIR);
         if (ill_c) begin
            stw_out_r <= stw_in_r;
            ptr_out_r <= ptr_in_r;
            ea_r <= 32'h0000_0000;
         end else begin
            result_r <= res_c;
            stw_out_r <= stw_c;
            ptr_out_r <= {dp_c[15:0], sp_c[15:0]};
            ea_r <= {dp_c[31:16], sp_c[31:16]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic ex;
   assign ex = state_r == ST_EXEC;

   a_word_fill: assert property (
      (ex && one_c && !byte_c && !ill_c) |=> (result_r[15:14] == {2{$past(opnd_r[15])}})
         && (result_r[13:0] == $past(opnd_r[14:1])))
      else $error("word one-bit shift wrong");
   a_byte_fill: assert property (
      (ex && byte_c && !ill_c) |=> result_r[7:0] == {$past(opnd_r[7]), $past(opnd_r[7:1])})
      else $error("byte one-bit shift wrong");
   a_carry_load: assert property (
      (ex && one_c && !ill_c) |=> stw_out_r[asru_pkg::STW_C] == $past(opnd_r[0]))
      else $error("carry not loaded from bit 0");
   a_mode_illegal: assert property (
      (ex && one_c && (pm > asru_pkg::M_PREDEC)) |=> ill_r)
      else $error("unsupported mode accepted");
   a_one_cycle: assert property (
      start |=> ex ##1 done_r)
      else $error("execution not done in one cycle");
   a_lit_shift: assert property (
      (ex && lit_c && !ill_c) |=> result_r == asr16($past(opnd_r), $past(instr_r[3:0])))
      else $error("literal shift wrong");
   a_carry_keep: assert property (
      (ex && (lit_c || reg_c)) |=>
         stw_out_r[asru_pkg::STW_C] == $past(stw_in_r[asru_pkg::STW_C]))
      else $error("multi-bit shift changed carry");
   a_cnt_low: assert property (
      (ex && reg_c && !sat_c) |=> result_r == asr16($past(opnd_r), $past(cnt_r[3:0])))
      else $error("count shift wrong");
   a_sat_fill: assert property (
      (ex && sat_c) |=> result_r == {16{$past(opnd_r[15])}})
      else $error("saturated shift wrong");
   a_zero_flag: assert property (
      (ex && !ill_c) |=> stw_out_r[asru_pkg::STW_Z] ==
         (byte_r ? (result_r[7:0] == 8'h00) : (result_r == 16'h0000)))
      else $error("zero flag does not match result");
   a_ptr_step: assert property (
      (ex && one_c && !ill_c && pm == asru_pkg::M_PINC) |=>
         ptr_out_r[15:0] == 16'($past(ptr_in_r[15:0]) + (byte_r ? 16'h0001 : 16'h0002)))
      else $error("pointer step wrong");

   c_byte_mem: cover property (ex && byte_c && pm == asru_pkg::M_PINC);
   c_lit_shift: cover property (ex && lit_c);
   c_sat_shift: cover property (ex && sat_c);
   c_illegal: cover property (ex && ill_c);
endmodule // asru_top

/* File: asru_pkg.sv */
// Package of offsets, instruction fields and status bits for the shift unit
package asru_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] A_INSTR = 8'h00;
   localparam logic [7:0] A_OPND = 8'h04;
   localparam logic [7:0] A_CNT = 8'h08;
   localparam logic [7:0] A_STW_IN = 8'h0C;
   localparam logic [7:0] A_PTR_IN = 8'h10;
   localparam logic [7:0] A_CTRL = 8'h14;
   localparam logic [7:0] A_RESULT = 8'h18;
   localparam logic [7:0] A_STW_OUT = 8'h1C;
   localparam logic [7:0] A_PTR_OUT = 8'h20;
   localparam logic [7:0] A_EA = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   localparam int unsigned OFFS_W = 8;
   // Instruction word fields
   localparam int unsigned INSTR_W = 24;
   localparam int unsigned F_OP_HI = 23;
   localparam int unsigned F_OP_LO = 15;
   localparam int unsigned F_B = 14;
   localparam int unsigned F_W_HI = 14;
   localparam int unsigned F_W_LO = 11;
   localparam int unsigned F_Q_HI = 13;
   localparam int unsigned F_Q_LO = 11;
   localparam int unsigned F_D_HI = 10;
   localparam int unsigned F_D_LO = 7;
   localparam int unsigned F_P_HI = 6;
   localparam int unsigned F_P_LO = 4;
   localparam int unsigned F_S_HI = 3;
   localparam int unsigned F_S_LO = 0;
   // Opcode patterns and count selectors
   localparam logic [8:0] OP_ONE = 9'h1A3;
   localparam logic [8:0] OP_MULTI = 9'h1BD;
   localparam logic [2:0] SEL_LIT = 3'h4;
   localparam logic [2:0] SEL_REG = 3'h0;
   // Addressing modes
   localparam logic [2:0] M_DIR = 3'h0;
   localparam logic [2:0] M_IND = 3'h1;
   localparam logic [2:0] M_PDEC = 3'h2;
   localparam logic [2:0] M_PINC = 3'h3;
   localparam logic [2:0] M_PREDEC = 3'h4;
   localparam logic [15:0] STEP_B = 16'h0001;
   localparam logic [15:0] STEP_W = 16'h0002;
   localparam logic [15:0] MAX_SHIFT = 16'h000F;
   // Status word bit positions
   localparam int unsigned STW_C = 0;
   localparam int unsigned STW_Z = 1;
   localparam int unsigned STW_N = 3;
   // Unit status and control bit positions
   localparam int unsigned ST_DONE = 0;
   localparam int unsigned ST_ILL = 1;
   localparam int unsigned ST_BYTE = 2;
   localparam int unsigned ST_DMEM = 3;
   localparam int unsigned ST_SMEM = 4;
   localparam int unsigned ST_DIDX = 8;
   localparam int unsigned CT_SAT = 0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: asru_host.sv */
// Register bus master standing in for the core decoder and register file
`timescale 1ns/1ps
module asru_host (
   // Clock
   input wire logic clk,
   // Write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   ////////////////////////////////////////////////////////////////////////////////
   // Quiet bus from time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // One write; released address and data lines flip so a stale value never passes as fresh
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] resp);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // One read; waits for the answer however long it takes
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
endmodule // asru_host

/* File: arith_shift_right_unit_tb_top.sv */
// Self-checking bench for the shift unit: bus and reset checks, table of operations, then hand-written cases
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module arith_shift_right_unit_tb_top;
   typedef struct {
      logic [23:0] ins;
      logic [15:0] op, cnt, sri;
      logic [31:0] pi;
      logic [15:0] res, sro;
      logic [31:0] po, ea;
      logic [15:0] st;
   } asru_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int n_errors = 0;
   int checked = 0;
   asru_row_t rows [12];

   ////////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   always #20 clk = ~clk;

   asru_top #(.ADDR_W(8)) u_asru_top (.clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   asru_host u_asru_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction builders for the one-bit and multi-bit forms
   function automatic logic [23:0] one(logic b, logic [2:0] q, logic [3:0] dr, logic [2:0] p,
                                       logic [3:0] s);
      return {asru_pkg::OP_ONE, b, q, dr, p, s};
   endfunction
   function automatic logic [23:0] mul(logic [3:0] w, dr, logic [2:0] sel, logic [3:0] k);
      return {asru_pkg::OP_MULTI, w, dr, sel, k};
   endfunction

   // Bus helpers; the response is always checked
   task automatic w(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = asru_pkg::RESP_OKAY);
      logic [1:0] r;
      u_asru_host.wr(a, v, s, r);
      `CHK(r, er)
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                     input logic [1:0] er = asru_pkg::RESP_OKAY);
      logic [31:0] v;
      logic [1:0] rs;
      u_asru_host.rd(a, v, rs);
      `CHK(rs, er)
      `CHK(v & m, e)
   endtask
   // Load operands, then the instruction write starts execution
   task automatic run(input asru_row_t x);
      w(asru_pkg::A_OPND, {16'h0000, x.op});
      w(asru_pkg::A_CNT, {16'h0000, x.cnt});
      w(asru_pkg::A_STW_IN, {16'h0000, x.sri});
      w(asru_pkg::A_PTR_IN, x.pi);
      w(asru_pkg::A_INSTR, {8'h00, x.ins});
   endtask

   task automatic end_sim();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rows[0] = '{one(0,0,13,0,12), 16'hAB01, 0, 16'hFFFF, 0, 16'hD580, 16'hFFFD, 0, 0, 16'h0D01};
      rows[1] = '{one(1,3,1,3,0), 16'h2366, 0, 0, 32'h0801_0600, 16'h0033, 0, 32'h0802_0601,
                  32'h0801_0600, 16'h011D};
      rows[2] = '{one(1,4,2,2,3), 16'h1281, 0, 0, 32'h0900_0500, 16'h00C0, 16'h0009,
                  32'h08FF_04FF, 32'h08FF_0500, 16'h021D};
      rows[3] = '{one(1,1,4,1,5), 16'hFF01, 0, 0, 32'h1234_5678, 0, 16'h0003, 32'h1234_5678,
                  32'h1234_5678, 16'h041D};
      rows[4] = '{one(0,2,6,4,7), 16'h0001, 0, 16'h0008, 32'h2000_3000, 0, 16'h0003,
                  32'h1FFE_2FFE, 32'h2000_2FFE, 16'h0619};
      rows[5] = '{mul(0,1,4,4), 16'h060F, 0, 16'h00F1, 0, 16'h0060, 16'h00F1, 0, 0, 16'h0101};
      rows[6] = '{mul(0,1,4,6), 16'h80FF, 0, 0, 0, 16'hFE03, 16'h0008, 0, 0, 16'h0101};
      rows[7] = '{mul(0,1,4,15), 16'h70FF, 0, 0, 0, 0, 16'h0002, 0, 0, 16'h0101};
      rows[8] = '{mul(3,9,4,0), 16'h8000, 0, 0, 0, 16'h8000, 16'h0008, 0, 0, 16'h0901};
      rows[9] = '{mul(0,6,0,5), 16'h80FF, 16'h0004, 16'h0001, 0, 16'hF80F, 16'h0009, 0, 0, 16'h0601};
      rows[10] = '{mul(0,6,0,5), 16'h6688, 16'h000A, 0, 0, 16'h0019, 0, 0, 0, 16'h0601};
      rows[11] = '{mul(0,13,0,12), 16'h8765, 16'h88E4, 0, 0, 16'hF876, 16'h0008, 0, 0, 16'h0D01};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, byte-lane merge, unmapped and misaligned places
      rc(asru_pkg::A_STAT, 0);
      rc(asru_pkg::A_OPND, 0);
      w(asru_pkg::A_OPND, 32'h0000_AAAA);
      w(asru_pkg::A_OPND, 32'h0000_1155, 4'h1);
      rc(asru_pkg::A_OPND, 32'h0000_AA55);
      w(8'h2C, 32'h1, 4'hF, asru_pkg::RESP_SLVERR);
      rc(8'h2C, 0, '1, asru_pkg::RESP_SLVERR);
      rc(8'h02, 0, '1, asru_pkg::RESP_SLVERR);
      // Table of ordinary operations, each read back before the next is issued
      for (int i = 0; i < 12; i++) begin
         run(rows[i]);
         rc(asru_pkg::A_RESULT, {16'h0000, rows[i].res});
         rc(asru_pkg::A_STW_OUT, {16'h0000, rows[i].sro});
         rc(asru_pkg::A_PTR_OUT, rows[i].po);
         rc(asru_pkg::A_EA, rows[i].ea);
         rc(asru_pkg::A_STAT, {16'h0000, rows[i].st});
      end
      // Read-only result ignores a write
      w(asru_pkg::A_RESULT, 32'h0000_1234);
      rc(asru_pkg::A_RESULT, 32'h0000_F876);
      // Saturating fill for counts above fifteen
      w(asru_pkg::A_CTRL, 32'h1);
      rc(asru_pkg::A_CTRL, 32'h1);
      run('{mul(0,6,0,5), 16'h8765, 16'h0010, 0, 0, 0, 0, 0, 0, 0});
      rc(asru_pkg::A_RESULT, 32'h0000_FFFF);
      run('{mul(0,6,0,5), 16'h0765, 16'h0020, 0, 0, 0, 0, 0, 0, 0});
      rc(asru_pkg::A_RESULT, 32'h0000_0000);
      rc(asru_pkg::A_STW_OUT, 32'h0000_0002);
      w(asru_pkg::A_CTRL, 32'h0);
      // Illegal mode and selector: flagged, result kept, input status word passed through
      run('{one(0,5,1,6,2), 16'h8001, 0, 16'h00F1, 0, 0, 0, 0, 0, 0});
      rc(asru_pkg::A_STAT, 32'h3, 32'h3);
      rc(asru_pkg::A_STW_OUT, 32'h0000_00F1);
      rc(asru_pkg::A_RESULT, 32'h0000_0000);
      run('{mul(0,1,2,4), 16'h8001, 0, 0, 0, 0, 0, 0, 0, 0});
      rc(asru_pkg::A_STAT, 32'h3, 32'h3);
      // Mid-run reset must clear status, operands and the held instruction
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rc(asru_pkg::A_STAT, 0);
      rc(asru_pkg::A_OPND, 0);
      rc(asru_pkg::A_INSTR, 0);
      end_sim();
   end
endmodule // arith_shift_right_unit_tb_top
